// ==== hw/flash_front_consts.vh ====
// opcodes, status field positions and sizes for the serial flash front end
`ifndef FLASH_FRONT_CONSTS_VH
`define FLASH_FRONT_CONSTS_VH

`define OP_WRITE_STATUS    8'h01
`define OP_WRITE_BYTES     8'h02
`define OP_READ_BYTES      8'h03
`define OP_WRITE_DISABLE   8'h04
`define OP_READ_STATUS     8'h05
`define OP_WRITE_ENABLE    8'h06
`define OP_ERASE_SUBSECTOR 8'h20
`define OP_ERASE_SECTOR    8'hD8
`define OP_ERASE_BULK      8'hC7
`define OP_ERASE_DIE       8'hC4
`define OP_WIDE_ENTRY      8'hB7
`define OP_WIDE_EXIT       8'hE9

`define STATUS_RESET       8'h00
`define SR_WIP             0
`define SR_WEL             1
`define SR_BP0             2
`define SR_BP1             3
`define SR_BP2             4
`define SR_TB              5
`define SR_BP3             6
`define SR_SPARE           7

`define ADDR_BYTES_NARROW  2'h2
`define ADDR_BYTES_WIDE    2'h3
`define SECTOR_MSB         25
`define SECTOR_LSB         16
`define SECTOR_TOTAL       11'h400
`define PROTECT_ALL_LEVEL  4'hB
`define IDLE_READ_BYTE     8'hFF

`endif

// ==== hw/pin_sync.v ====
// two-flop synchroniser for pins from the serial link
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 1'b0
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_reg <= {WIDTH{RESET_VAL}};
      q        <= {WIDTH{RESET_VAL}};
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // pin_sync

`default_nettype wire

// ==== hw/read_buffer.v ====
// two-entry valid/ready buffer for read bytes
`timescale 1ns/10ps
`default_nettype none

module read_buffer #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);

  reg [WIDTH-1:0] head_reg;
  reg [WIDTH-1:0] tail_reg;
  reg [1:0]       cnt_reg;
  reg [1:0]       cnt_next;
  wire            push;
  wire            pop;

  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = head_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @*
  begin
    cnt_next = cnt_reg;
    if (push & !pop)
      cnt_next = cnt_reg + 2'h1;
    else if (pop & !push)
      cnt_next = cnt_reg - 2'h1;
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      head_reg <= {WIDTH{1'b0}};
      tail_reg <= {WIDTH{1'b0}};
      cnt_reg  <= 2'h0;
      in_ready <= 1'b1;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      in_ready <= (cnt_next != 2'h2);
      if (pop)
        head_reg <= (cnt_reg == 2'h2) ? tail_reg : in_data;
      else if (push & (cnt_reg == 2'h0))
        head_reg <= in_data;
      if (push & !pop & (cnt_reg == 2'h1))
        tail_reg <= in_data;
    end
  end

endmodule // read_buffer

`default_nettype wire

// ==== hw/flash_cmd_front_end.v ====
// serial command front end: framing, addressing mode and status flags
`timescale 1ns/10ps
`default_nettype none
`include "flash_front_consts.vh"

// What this block does and what its host must do
// RQ1: bytes travel most significant bit first
// RQ2: select low, bits taken on clock rise
// RQ3: host sends opcode then address, data
// RQ4: host ends non-read frames after last bit
// RQ5: read shifts data out until select rises
// RQ6: host ends writes, erases on byte boundary
// RQ7: non-boundary end discards write or erase
// RQ8: memory access rejected while cycle runs
// RQ9: three-byte addresses until wide mode entered
// RQ10: wide mode decodes full 32-bit address
// RQ11: host enters wide mode for big arrays
// RQ12: entry op is immediate and kept persistently
// RQ13: only exit op returns to three bytes
// RQ14: 1024 sectors, top subsector ends 3FFFFFF
// RQ15: protect level bits 6,4:2 reset zero
// RQ16: bit 5 picks bottom or top origin
// RQ17: write latch bit 1 gates writes, erases
// RQ18: bit 0 high while internal cycle runs
// RQ19: bulk erase needs zero level; region blocked
// RQ20: highest level bit only on large variants
// RQ21: select high clears shift state, counter
module flash_cmd_front_end (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        select_low_line,
  input  wire        serial_shift_clock,
  input  wire        data_in,
  output reg         data_out,
  output reg         data_oe_n,
  output reg         cmd_valid,
  output reg  [7:0]  cmd_op,
  output reg  [31:0] cmd_addr,
  output reg         cmd_reject,
  output reg         wr_valid,
  output reg  [7:0]  wr_data,
  output reg         wide_mode,
  input  wire        persist_wide_in,
  input  wire        op_done,
  input  wire        rd_in_valid,
  input  wire [7:0]  rd_in_data,
  output wire        rd_in_ready
);

  localparam ST_OP    = 6'b000001;
  localparam ST_ADDR  = 6'b000010;
  localparam ST_WDATA = 6'b000100;
  localparam ST_RDOUT = 6'b001000;
  localparam ST_SROUT = 6'b010000;
  localparam ST_WAIT  = 6'b100000;
  localparam [7:0] STATUS_INIT = `STATUS_RESET;

  wire [2:0]  pins_q;
  wire        sel_n;
  wire        sclk;
  wire        din;
  reg         sclk_prev_reg;
  reg         sel_prev_reg;
  reg         init_reg;
  reg  [5:0]  state_reg;
  reg  [2:0]  bitcnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  out_shift_reg;
  reg  [7:0]  op_reg;
  reg  [31:0] addr_reg;
  reg  [1:0]  addr_cnt_reg;
  reg         done_reg;
  reg  [7:0]  wrsr_byte_reg;
  reg  [7:2]  sr_reg;
  reg         wel_reg;
  reg         wip_reg;

  wire        sclk_rise;
  wire        sclk_fall;
  wire        frame_end;
  wire [7:0]  byte_next;
  wire [31:0] addr_next;
  wire [7:0]  status_byte;
  wire [3:0]  level;
  wire [9:0]  sector;
  reg  [10:0] prot_count;
  wire        prot_hit;
  wire        last_addr_byte;
  wire        is_prog_op;
  wire        is_addr_op;
  wire        buf_valid;
  wire [7:0]  buf_data;
  wire        pop_now;
  wire [7:0]  next_out;

  pin_sync #(
    .WIDTH     (3),
    .RESET_VAL (1'b1)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({select_low_line, serial_shift_clock, data_in}),
    .q       (pins_q)
  );

  assign sel_n     = pins_q[2];
  assign sclk      = pins_q[1];
  assign din       = pins_q[0];
  assign sclk_rise = !sel_n & sclk & !sclk_prev_reg; // RQ2
  assign sclk_fall = !sel_n & !sclk & sclk_prev_reg;
  assign frame_end = sel_n & !sel_prev_reg;
  assign byte_next = {shift_reg[6:0], din}; // RQ1
  assign addr_next = {addr_reg[23:0], byte_next};

  // bit 7 is a plain read/write bit; bits 6..2 are protection
  assign status_byte = {sr_reg, wel_reg, wip_reg};
  assign level = {sr_reg[`SR_BP3], sr_reg[`SR_BP2],
                  sr_reg[`SR_BP1], sr_reg[`SR_BP0]}; // RQ15 RQ20
  assign sector = addr_next[`SECTOR_MSB:`SECTOR_LSB]; // RQ14

  // level n protects 2^(n-1) sectors, saturating at the whole array
  always @*
  begin
    prot_count = 11'h000;
    if (level >= `PROTECT_ALL_LEVEL)
      prot_count = `SECTOR_TOTAL;
    else if (level != 4'h0)
      prot_count = 11'h001 << (level - 4'h1);
  end

  // RQ16 RQ19
  assign prot_hit = sr_reg[`SR_TB] ?
                    ({1'b0, sector} < prot_count) :
                    ({1'b0, sector} >= (`SECTOR_TOTAL - prot_count));

  // RQ9 RQ10
  assign last_addr_byte = (addr_cnt_reg ==
                          (wide_mode ? `ADDR_BYTES_WIDE
                                     : `ADDR_BYTES_NARROW));

  assign is_addr_op = (op_reg == `OP_WRITE_BYTES) |
                      (op_reg == `OP_ERASE_SECTOR) |
                      (op_reg == `OP_ERASE_SUBSECTOR);
  assign is_prog_op = is_addr_op |
                      (op_reg == `OP_WRITE_STATUS) |
                      (op_reg == `OP_ERASE_BULK) |
                      (op_reg == `OP_ERASE_DIE);

  // only pop at the start of an output byte; an empty buffer
  // sends idle ones, so the array must keep ahead of the host
  assign pop_now  = sclk_fall & (state_reg == ST_RDOUT) &
                    (bitcnt_reg == 3'h0);
  assign next_out = buf_valid ? buf_data : `IDLE_READ_BYTE;

  // outside a read, drain so stale bytes never reach the next one
  read_buffer #(
    .WIDTH (8)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (rd_in_valid),
    .in_data   (rd_in_data),
    .in_ready  (rd_in_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (pop_now | (state_reg != ST_RDOUT))
  );

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sclk_prev_reg <= 1'b0;
      sel_prev_reg  <= 1'b1;
      init_reg      <= 1'b0;
      state_reg     <= ST_OP;
      bitcnt_reg    <= 3'h0;
      shift_reg     <= 8'h00;
      out_shift_reg <= 8'h00;
      op_reg        <= 8'h00;
      addr_reg      <= 32'h0000_0000;
      addr_cnt_reg  <= 2'h0;
      done_reg      <= 1'b0;
      wrsr_byte_reg <= 8'h00;
      sr_reg        <= STATUS_INIT[7:2];
      wel_reg       <= 1'b0;
      wip_reg       <= 1'b0;
      data_out      <= 1'b1;
      data_oe_n     <= 1'b1;
      cmd_valid     <= 1'b0;
      cmd_op        <= 8'h00;
      cmd_addr      <= 32'h0000_0000;
      cmd_reject    <= 1'b0;
      wr_valid      <= 1'b0;
      wr_data       <= 8'h00;
      wide_mode     <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= sclk;
      sel_prev_reg  <= sel_n;
      cmd_valid     <= 1'b0;
      cmd_reject    <= 1'b0;
      wr_valid      <= 1'b0;
      // the mode stored in the array is taken once after reset
      init_reg <= 1'b1;
      if (!init_reg)
        wide_mode <= persist_wide_in; // RQ12
      // clear first so a commit in the same cycle wins
      if (op_done)
        wip_reg <= 1'b0; // RQ18
      if (sel_n)
      begin
        state_reg    <= ST_OP; // RQ21
        bitcnt_reg   <= 3'h0;
        shift_reg    <= 8'h00;
        addr_reg     <= 32'h0000_0000;
        addr_cnt_reg <= 2'h0;
        done_reg     <= 1'b0;
        data_oe_n    <= 1'b1;
        if (frame_end & done_reg & (bitcnt_reg == 3'h0))
        begin
          if (op_reg == `OP_WRITE_ENABLE)
            wel_reg <= 1'b1;
          else if (op_reg == `OP_WRITE_DISABLE)
            wel_reg <= 1'b0;
          else if (op_reg == `OP_WIDE_ENTRY)
            wide_mode <= 1'b1; // RQ12
          else if (op_reg == `OP_WIDE_EXIT)
            wide_mode <= 1'b0; // RQ13
          else if (is_prog_op)
          begin
            if (op_reg == `OP_WRITE_STATUS)
              sr_reg <= wrsr_byte_reg[7:2]; // RQ15
            wel_reg   <= 1'b0;
            wip_reg   <= 1'b1; // RQ18
            cmd_valid <= 1'b1;
            cmd_op    <= op_reg;
          end
        end
        else if (frame_end & done_reg & is_prog_op)
          cmd_reject <= 1'b1; // RQ7
      end
      else if (sclk_rise)
      begin
        shift_reg  <= byte_next;
        bitcnt_reg <= bitcnt_reg + 3'h1;
        if (bitcnt_reg == 3'h7)
        begin
          case (state_reg)
            ST_OP:
            begin
              op_reg    <= byte_next;
              state_reg <= ST_WAIT;
              if ((byte_next == `OP_WRITE_ENABLE) |
                  (byte_next == `OP_WRITE_DISABLE) |
                  (byte_next == `OP_WIDE_ENTRY) |
                  (byte_next == `OP_WIDE_EXIT))
                done_reg <= 1'b1;
              else if (byte_next == `OP_READ_STATUS)
                state_reg <= ST_SROUT;
              else if (byte_next == `OP_READ_BYTES)
              begin
                if (wip_reg)
                  cmd_reject <= 1'b1; // RQ8
                else
                  state_reg <= ST_ADDR;
              end
              else if ((byte_next == `OP_WRITE_BYTES) |
                       (byte_next == `OP_ERASE_SECTOR) |
                       (byte_next == `OP_ERASE_SUBSECTOR) |
                       (byte_next == `OP_WRITE_STATUS))
              begin
                if (wip_reg | !wel_reg)
                  cmd_reject <= 1'b1; // RQ8 RQ17
                else if (byte_next == `OP_WRITE_STATUS)
                  state_reg <= ST_WDATA;
                else
                  state_reg <= ST_ADDR;
              end
              else if ((byte_next == `OP_ERASE_BULK) |
                       (byte_next == `OP_ERASE_DIE))
              begin
                if (wip_reg | !wel_reg | (level != 4'h0))
                  cmd_reject <= 1'b1; // RQ17 RQ19
                else
                  done_reg <= 1'b1;
              end
              else
                cmd_reject <= 1'b1;
            end
            ST_ADDR:
            begin
              addr_reg     <= addr_next; // RQ10
              addr_cnt_reg <= addr_cnt_reg + 2'h1;
              if (last_addr_byte)
              begin
                cmd_addr <= addr_next;
                if (op_reg == `OP_READ_BYTES)
                begin
                  // reads start at once; no select edge follows
                  cmd_valid <= 1'b1; // RQ5
                  cmd_op    <= op_reg;
                  state_reg <= ST_RDOUT;
                end
                else if (prot_hit)
                begin
                  cmd_reject <= 1'b1; // RQ19
                  state_reg  <= ST_WAIT;
                end
                else if (op_reg == `OP_WRITE_BYTES)
                  state_reg <= ST_WDATA;
                else
                begin
                  done_reg  <= 1'b1;
                  state_reg <= ST_WAIT;
                end
              end
            end
            ST_WDATA:
            begin
              done_reg <= 1'b1;
              if (op_reg == `OP_WRITE_STATUS)
              begin
                wrsr_byte_reg <= byte_next;
                state_reg     <= ST_WAIT;
              end
              else
              begin
                wr_valid <= 1'b1;
                wr_data  <= byte_next;
              end
            end
            default:
            begin
              state_reg <= state_reg;
            end
          endcase
        end
      end
      else if (sclk_fall &
               ((state_reg == ST_RDOUT) | (state_reg == ST_SROUT)))
      begin
        data_oe_n <= 1'b0;
        if (bitcnt_reg == 3'h0)
        begin
          if (state_reg == ST_SROUT)
          begin
            data_out      <= status_byte[7]; // RQ1
            out_shift_reg <= {status_byte[6:0], 1'b0};
          end
          else
          begin
            data_out      <= next_out[7]; // RQ5
            out_shift_reg <= {next_out[6:0], 1'b0};
          end
        end
        else
        begin
          data_out      <= out_shift_reg[7];
          out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

endmodule // flash_cmd_front_end

`default_nettype wire

// ==== dv/flash_front_chk.sv ====
// port assertions for the serial flash command front end
`timescale 1ns/10ps
`default_nettype none
module flash_front_chk (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       select_low_line,
  input wire logic       serial_shift_clock,
  input wire logic       data_out,
  input wire logic       data_oe_n,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic       cmd_reject,
  input wire logic       wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic       wide_mode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  rst_vals_a: assert property ($rose(rst_n) |-> data_oe_n && data_out
    && !cmd_valid && !cmd_reject && !wr_valid && !wide_mode)
    else $error("outputs not at reset values");
  commit_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("commit longer than one cycle");
  refuse_excl_a: assert property (!(cmd_valid && cmd_reject))
    else $error("commit and refusal together");
  refuse_pulse_a: assert property (cmd_reject |=> !cmd_reject)
    else $error("refusal longer than one cycle");
  // write strobes are at least nine system clocks apart
  wr_spacing_a: assert property (wr_valid |=> !wr_valid [*8])
    else $error("write bytes too close");
  oe_idle_a: assert property (select_low_line [*6] |-> data_oe_n)
    else $error("data pin driven outside a frame");
  dout_hold_a: assert property (
    (serial_shift_clock && !data_oe_n) [*3] |-> $stable(data_out))
    else $error("read bit moved while clock high");
  // mode may only move at a frame end or once after reset, never in mid-frame
  wide_hold_a: assert property (
    (!select_low_line) [*6] ##0 $past(rst_n, 2) |-> $stable(wide_mode))
    else $error("address mode moved inside a frame");
  op_hold_a: assert property (!cmd_valid |-> $stable(cmd_op))
    else $error("opcode moved without commit");
  wd_hold_a: assert property (!wr_valid |-> $stable(wr_data))
    else $error("write byte moved without strobe");
  cover property (cmd_valid && cmd_op == 8'h03);
  cover property (cmd_reject);
  cover property (wr_valid);
  cover property ($rose(wide_mode));
endmodule // flash_front_chk

bind flash_cmd_front_end flash_front_chk chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .select_low_line(select_low_line),
  .serial_shift_clock(serial_shift_clock), .data_out(data_out),
  .data_oe_n(data_oe_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_reject(cmd_reject), .wr_valid(wr_valid), .wr_data(wr_data),
  .wide_mode(wide_mode)
);
`default_nettype wire

// ==== dv/host_link.sv ====
// host model driving select, serial clock and data pins
`timescale 1ns/10ps
`default_nettype none
module host_link (
  output logic      select_low_line,
  output logic      serial_shift_clock,
  output logic      data_in,
  input  wire logic data_out,
  input  wire logic data_oe_n
);
  initial
  begin
    select_low_line = 1'b1;
    serial_shift_clock = 1'b0;
    data_in = 1'b0;
  end
  // odd offset keeps link edges off the system clock phase
  task automatic open_frame();
    #3.3 select_low_line = 1'b0;
    #100;
  endtask
  task automatic xfer(input int n, input logic [7:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      data_in = tx[i];
      #100 serial_shift_clock = 1'b1;
      // a released pin reads as the inverse, so a missing enable shows
      #100 rx = {rx[6:0], data_oe_n ? ~data_out : data_out};
      serial_shift_clock = 1'b0;
    end
  endtask
  // clock stands low between frames; released data shows no stale value
  task automatic close_frame();
    #100 select_low_line = 1'b1;
    data_in = ~data_in;
    #300;
  endtask
endmodule // host_link
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the serial flash command front end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  wire logic   select_low_line, serial_shift_clock, data_in;
  logic        clk_sys, rst_n, persist_wide_in, op_done, feed;
  logic        data_out, data_oe_n, cmd_valid, cmd_reject, wr_valid;
  logic        wide_mode, rd_in_ready, dn;
  logic [7:0]  cmd_op, wr_data, rd_in_data, last_op, op, st, s, last_wr;
  logic [7:0]  tx_q[$], rx_q[$];
  logic [31:0] cmd_addr, last_addr;
  logic [2:0]  nb;
  logic [1:0]  vr;
  int          num_errors = 0, check_count = 0;
  int          nv = 0, nr = 0, bv, br, dv, dr;
  // opcode, extra bytes, {commit, refuse}, status after, finish cycle
  localparam logic [21:0] rows [16] = '{
    {8'h02, 3'h4, 2'h1, 8'h00, 1'h0}, {8'h06, 3'h0, 2'h0, 8'h02, 1'h0},
    {8'h02, 3'h4, 2'h2, 8'h01, 1'h0}, {8'h03, 3'h3, 2'h1, 8'h01, 1'h1},
    {8'h06, 3'h0, 2'h0, 8'h02, 1'h0}, {8'h04, 3'h0, 2'h0, 8'h00, 1'h0},
    {8'hD8, 3'h3, 2'h1, 8'h00, 1'h0}, {8'h06, 3'h0, 2'h0, 8'h02, 1'h0},
    {8'h20, 3'h3, 2'h2, 8'h01, 1'h1}, {8'h06, 3'h0, 2'h0, 8'h02, 1'h0},
    {8'h01, 3'h1, 2'h2, 8'h3D, 1'h1}, {8'h06, 3'h0, 2'h0, 8'h3E, 1'h0},
    {8'hC7, 3'h0, 2'h1, 8'h3E, 1'h0}, {8'hC4, 3'h0, 2'h1, 8'h3E, 1'h0},
    {8'hD8, 3'h3, 2'h1, 8'h3E, 1'h0}, {8'h5A, 3'h0, 2'h1, 8'h3E, 1'h0}};

  flash_cmd_front_end DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .select_low_line(select_low_line),
    .serial_shift_clock(serial_shift_clock), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_reject(cmd_reject),
    .wr_valid(wr_valid), .wr_data(wr_data), .wide_mode(wide_mode),
    .persist_wide_in(persist_wide_in), .op_done(op_done),
    .rd_in_valid(feed), .rd_in_data(rd_in_data), .rd_in_ready(rd_in_ready)
  );
  host_link host (
    .select_low_line(select_low_line), .data_out(data_out),
    .serial_shift_clock(serial_shift_clock), .data_in(data_in),
    .data_oe_n(data_oe_n)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // array side: feeds a counting byte stream while a read is open
  always @(posedge clk_sys)
  begin
    if (cmd_valid === 1'b1)
    begin
      nv <= nv + 1;
      last_op <= cmd_op;
      last_addr <= cmd_addr;
    end
    if (cmd_reject === 1'b1)
      nr <= nr + 1;
    if (wr_valid === 1'b1)
      last_wr <= wr_data;
    if (cmd_valid === 1'b1 && cmd_op === 8'h03)
    begin
      feed <= #1 1'b1;
      rd_in_data <= #1 8'hA5;
    end
    else if (select_low_line)
      feed <= #1 1'b0;
    else if (feed && rd_in_ready === 1'b1)
      rd_in_data <= #1 rd_in_data + 8'h01;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic frame(input int tail, input int nrd);
    logic [7:0] r;
    rx_q = {};
    bv = nv;
    br = nr;
    host.open_frame();
    foreach (tx_q[i]) host.xfer(8, tx_q[i], r);
    repeat (nrd)
    begin
      host.xfer(8, 8'h00, r);
      rx_q.push_back(r);
    end
    if (tail > 0) host.xfer(tail, 8'h00, r);
    host.close_frame();
    tx_q = {};
    dv = nv - bv;
    dr = nr - br;
  endtask

  task automatic read_status(output logic [7:0] v);
    tx_q = {8'h05};
    frame(0, 1);
    v = rx_q[0];
  endtask

  task automatic pulse_done();
    @(posedge clk_sys);
    #1 op_done = 1'b1;
    @(posedge clk_sys);
    #1 op_done = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #2000000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    persist_wide_in = 1'b0;
    op_done = 1'b0;
    feed = 1'b0;
    rd_in_data = 8'hA5;
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(wide_mode, 1'b0, "mode after reset");
    chk(data_oe_n, 1'b1, "pin idle");
    chk(rd_in_ready, 1'b1, "buffer ready");
    foreach (rows[i])
    begin
      {op, nb, vr, st, dn} = rows[i];
      tx_q.push_back(op);
      // 3C as status data sets bottom origin, level 7: sectors 0..63
      repeat (nb) tx_q.push_back(8'h3C);
      frame(0, 0);
      chk(dv, vr[1], "commit count");
      chk(dr, vr[0], "refuse count");
      if (vr[1]) chk(last_op, op, "opcode");
      read_status(s);
      chk(s, st, "status");
      if (dn) pulse_done();
    end
    $display("test table done");
    // narrow address: upper byte reads as zero
    tx_q = {8'h03, 8'hAB, 8'hCD, 8'hEF};
    frame(0, 2);
    chk(last_addr, 32'h00ABCDEF, "narrow address");
    chk(rx_q[0], 8'hA5, "read byte 0");
    chk(rx_q[1], 8'hA6, "read byte 1");
    $display("test narrow read done");
    tx_q = {8'hB7};
    frame(0, 0);
    chk(wide_mode, 1'b1, "mode on");
    tx_q = {8'h03, 8'h01, 8'h23, 8'h45, 8'h67};
    frame(0, 1);
    chk(last_addr, 32'h01234567, "wide address");
    chk(rx_q[0], 8'hA5, "wide read byte");
    tx_q = {8'hE9};
    frame(0, 0);
    chk(wide_mode, 1'b0, "mode off");
    $display("test wide mode done");
    // write frame cut five bits into its second data byte
    tx_q = {8'h06};
    frame(0, 0);
    tx_q = {8'h02, 8'h80, 8'h00, 8'h00, 8'h55};
    frame(5, 0);
    chk(dv, 0, "cut commit");
    chk(dr, 1, "cut refuse");
    chk(last_wr, 8'h55, "write byte");
    read_status(s);
    chk(s, 8'h3E, "cut not run");
    $display("test cut frame done");
    tx_q = {8'hB7};
    frame(0, 0);
    // the stored copy follows the mode that the block reports
    persist_wide_in = wide_mode;
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(wide_mode, 1'b1, "mode kept");
    $display("test persistence done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
